// File: hw/self_program_flash_control.sv
// Self-programming sequencer: control/status register, store and load
// command windows, page erase/write, buffer fill, lock write and readback.
// Assumes the core, flash array and EEPROM logic all run on CORE_CLK;
// only the programming-mode strap arrives from a pin.
`timescale 1ns/1ns
`include "spm_ctrl_defs.svh"

module self_program_flash_control (
  // Clock and reset
  input  wire logic        CORE_CLK,
  input  wire logic        RESET,
  // Control/status register port
  input  wire logic        CSR_WR_EN,
  input  wire logic [7:0]  CSR_WR_DATA,
  output logic      [7:0]  CSR_RD_DATA,
  // Core instruction strobes and operands
  input  wire logic        STORE_PROG_MEM_OP,
  input  wire logic        LOAD_PROG_MEM_OP,
  input  wire logic [15:0] Z_PTR,
  input  wire logic [7:0]  LOW_DATA_REG,
  input  wire logic [7:0]  HIGH_DATA_REG,
  input  wire logic        GLOBAL_IRQ_EN,
  // Core answers
  output logic             LOAD_OVERRIDE,
  output logic      [7:0]  LOAD_DATA,
  output logic             CPU_HALT,
  output logic             PROG_READY_IRQ,
  // Flash array
  output logic             PAGE_ERASE_START,
  output logic             PAGE_WRITE_START,
  output logic      [6:0]  PAGE_ADDR,
  output logic             BUF_WR,
  output logic      [5:0]  BUF_WORD,
  output logic      [15:0] BUF_DATA,
  output logic             BUF_CLEAR,
  input  wire logic        FLASH_DONE,
  // Lock and fuse storage
  input  wire logic [7:0]  LOCK_BITS_NV,
  output logic             LOCK_PROG,
  output logic      [7:0]  LOCK_PROG_DATA,
  input  wire logic [7:0]  FUSE_LOW_RAW,
  input  wire logic [7:0]  FUSE_HIGH_RAW,
  input  wire logic        FUSE_WR_REQ,
  output logic             FUSE_WR_GRANT,
  output logic      [7:0]  FUSE_LOW,
  output logic      [7:0]  FUSE_HIGH,
  // EEPROM and programming mode
  input  wire logic        EEPROM_WRITE_ACTIVE,
  input  wire logic        PROG_MODE_PIN
);

  spm_ctrl_pkg::seq_state_e state_q;
  spm_ctrl_pkg::seq_state_e state_d;

  // Control bits.
  logic       irq_en_q;
  logic [4:0] cmd_q;
  logic [4:0] cmd_d;
  logic       filling_q;
  logic       pm_meta_q;
  logic       pm_sync_q;

  // Registered outputs.
  logic                     irq_q;
  logic                     halt_q;
  logic                     ld_ovr_q;
  spm_ctrl_pkg::byte_t      ld_data_q;
  logic                     ers_q;
  logic                     wrt_q;
  logic [6:0]               page_q;
  logic                     bwr_q;
  logic [5:0]               bword_q;
  logic [15:0]              bdata_q;
  logic                     bclr_q;
  logic                     lprog_q;
  spm_ctrl_pkg::byte_t      ldat_q;
  logic                     fgrant_q;

  // Write decode.
  logic       csr_wr;
  logic [4:0] wr_cmd;
  logic       arm_cmd;
  logic       is_fill;
  logic       is_erase;
  logic       is_write;
  logic       is_lock;

  // Window counters.
  logic       st_open;
  logic       st_expire;
  logic       ld_open;
  logic       ld_expire;
  logic       st_hit;
  logic       ld_hit;
  logic       ld_read;
  logic       window_end;
  logic       page_done;

  // Load readback.
  spm_ctrl_pkg::byte_t rd_sel;
  spm_ctrl_pkg::byte_t fuse_low_w;
  spm_ctrl_pkg::byte_t fuse_high_w;
  logic                fuse_frozen;

  // Interrupt condition.
  logic       irq_d;

  // A write is refused while the EEPROM is being written.
  assign csr_wr   = CSR_WR_EN && !EEPROM_WRITE_ACTIVE;
  assign wr_cmd   = CSR_WR_DATA[4:0] & 5'(`CSR_CMD_MASK);
  assign arm_cmd  = csr_wr && wr_cmd[`CSR_SELF_EN_BIT] && (state_q != spm_ctrl_pkg::ST_BUSY);

  assign is_fill  = (cmd_q == `PAT_FILL);
  assign is_erase = (cmd_q == `PAT_ERASE);
  assign is_write = (cmd_q == `PAT_WRITE);
  assign is_lock  = (cmd_q == `PAT_LOCK);

  // Stores and loads only act on an armed window and outside EEPROM writes.
  assign st_hit   = STORE_PROG_MEM_OP && st_open && (state_q == spm_ctrl_pkg::ST_ARMED)
                    && !EEPROM_WRITE_ACTIVE;
  assign ld_read  = is_lock && ld_open && (state_q == spm_ctrl_pkg::ST_ARMED);
  assign ld_hit   = LOAD_PROG_MEM_OP && ld_read && !EEPROM_WRITE_ACTIVE;

  // Both windows close the lock-set arming; other commands only the store one.
  assign window_end = is_lock ? (ld_expire || st_expire) : st_expire;
  assign page_done  = (state_q == spm_ctrl_pkg::ST_BUSY) && FLASH_DONE;

  cmd_window #(
    .WIDTH (3),
    .LOAD  (`STORE_WINDOW_CYC)
  ) u_store_window (
    .clk    (CORE_CLK),
    .rst    (RESET),
    .start  (arm_cmd),
    .stop   (st_hit || ld_hit),
    .open   (st_open),
    .expire (st_expire)
  );

  cmd_window #(
    .WIDTH (3),
    .LOAD  (`LOAD_WINDOW_CYC)
  ) u_load_window (
    .clk    (CORE_CLK),
    .rst    (RESET),
    .start  (arm_cmd && (wr_cmd == `PAT_LOCK)),
    .stop   (st_hit || ld_hit),
    .open   (ld_open),
    .expire (ld_expire)
  );

  always_comb begin
    state_d = state_q;
    cmd_d   = cmd_q;
    case (state_q)
      spm_ctrl_pkg::ST_IDLE: begin
        if (arm_cmd) begin
          state_d = spm_ctrl_pkg::ST_ARMED;
          cmd_d   = wr_cmd;
        end
      end
      spm_ctrl_pkg::ST_ARMED: begin
        if (arm_cmd) begin
          cmd_d = wr_cmd;
        end else if (st_hit && (is_erase || is_write)) begin
          state_d = spm_ctrl_pkg::ST_BUSY;
        end else if (st_hit || ld_hit || window_end) begin
          state_d = spm_ctrl_pkg::ST_IDLE;
          cmd_d   = 5'h00;
        end
      end
      spm_ctrl_pkg::ST_BUSY: begin
        if (FLASH_DONE) begin
          state_d = spm_ctrl_pkg::ST_IDLE;
          cmd_d   = 5'h00;
        end
      end
      default: begin
        state_d = spm_ctrl_pkg::ST_IDLE;
        cmd_d   = 5'h00;
      end
    endcase
  end

  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      state_q  <= spm_ctrl_pkg::ST_IDLE;
      cmd_q    <= 5'h00;
      irq_en_q <= 1'b0;
    end else begin
      state_q  <= state_d;
      cmd_q    <= cmd_d;
      if (csr_wr) begin
        irq_en_q <= CSR_WR_DATA[`CSR_IRQ_EN_BIT];
      end
    end
  end

  // Busy bit and reserved bit read as zero; the reserved write is dropped.
  assign CSR_RD_DATA = {irq_en_q, 1'b0, 1'b0, cmd_q};

  // Readback byte by pointer; the load answers one cycle after the strobe.
  always_comb begin
    case (Z_PTR[1:0])
      `Z_FUSE_LOW:  rd_sel = fuse_low_w;
      `Z_LOCK:      rd_sel = LOCK_BITS_NV;
      `Z_FUSE_HIGH: rd_sel = fuse_high_w;
      default:      rd_sel = `RD_UNUSED;
    endcase
  end

  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      ld_ovr_q  <= 1'b0;
      ld_data_q <= 8'h00;
    end else begin
      ld_ovr_q  <= ld_hit;
      if (ld_hit) begin
        ld_data_q <= rd_sel;
      end
    end
  end

  // Page commands take the page from Z13:Z7; Z15:Z14 and Z0 are not looked at.
  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      ers_q   <= 1'b0;
      wrt_q   <= 1'b0;
      page_q  <= 7'h00;
      bwr_q   <= 1'b0;
      bword_q <= 6'h00;
      bdata_q <= 16'h0000;
      lprog_q <= 1'b0;
      ldat_q  <= 8'hff;
    end else begin
      ers_q   <= st_hit && is_erase;
      wrt_q   <= st_hit && is_write;
      bwr_q   <= st_hit && is_fill;
      lprog_q <= st_hit && is_lock;
      if (st_hit && (is_erase || is_write)) begin
        page_q <= Z_PTR[`Z_PAGE_MSB:`Z_PAGE_LSB];
      end
      if (st_hit && is_fill) begin
        bword_q <= Z_PTR[`Z_WORD_MSB:`Z_WORD_LSB];
        bdata_q <= {HIGH_DATA_REG, LOW_DATA_REG};
      end
      if (st_hit && is_lock) begin
        // Pointer is ignored; only data bits 5..2 can program a lock bit.
        ldat_q <= LOW_DATA_REG | `LOCK_KEEP_MASK;
      end
    end
  end

  // Buffer fill tracking and the read-enable clear.
  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      filling_q <= 1'b0;
      bclr_q    <= 1'b0;
    end else begin
      bclr_q <= csr_wr && CSR_WR_DATA[`CSR_RWW_RD_EN_BIT] && filling_q;
      if ((st_hit && is_fill) && !(page_done && is_write)) begin
        filling_q <= 1'b1;
      end else if (bclr_q || (page_done && is_write)) begin
        filling_q <= 1'b0;
      end
    end
  end

  // The core is held only for page erase and write; lock writes leave the
  // flash readable so the core keeps fetching.
  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      halt_q <= 1'b0;
    end else if (st_hit && (is_erase || is_write)) begin
      halt_q <= 1'b1;
    end else if (page_done) begin
      halt_q <= 1'b0;
    end
  end

  // Ready interrupt: level request while self-enable is clear and no EEPROM write is active.
  assign irq_d = irq_en_q && GLOBAL_IRQ_EN && !cmd_q[`CSR_SELF_EN_BIT]
                 && !EEPROM_WRITE_ACTIVE && (state_q != spm_ctrl_pkg::ST_BUSY);

  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= irq_d;
    end
  end

  // Programming-mode strap comes from a pin.
  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      pm_meta_q <= 1'b0;
      pm_sync_q <= 1'b0;
    end else begin
      pm_meta_q <= PROG_MODE_PIN;
      pm_sync_q <= pm_meta_q;
    end
  end

  // Fuses live outside the flash array, so chip erase never reaches them;
  // once the first lock bit is programmed (zero) fuse writes are refused.
  assign fuse_frozen = !LOCK_BITS_NV[`LOCK_FIRST_BIT];

  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      fgrant_q <= 1'b0;
    end else begin
      fgrant_q <= FUSE_WR_REQ && !fuse_frozen;
    end
  end

  fuse_latch #(
    .IMM_MASK (8'h00)
  ) u_fuse_low (
    .clk       (CORE_CLK),
    .rst       (RESET),
    .raw       (FUSE_LOW_RAW),
    .prog_mode (pm_sync_q),
    .value     (fuse_low_w)
  );

  fuse_latch #(
    .IMM_MASK (`FUSE_HIGH_IMM_MASK)
  ) u_fuse_high (
    .clk       (CORE_CLK),
    .rst       (RESET),
    .raw       (FUSE_HIGH_RAW),
    .prog_mode (pm_sync_q),
    .value     (fuse_high_w)
  );

  assign PROG_READY_IRQ   = irq_q;
  assign CPU_HALT         = halt_q;
  assign LOAD_OVERRIDE    = ld_ovr_q;
  assign LOAD_DATA        = ld_data_q;
  assign PAGE_ERASE_START = ers_q;
  assign PAGE_WRITE_START = wrt_q;
  assign PAGE_ADDR        = page_q;
  assign BUF_WR           = bwr_q;
  assign BUF_WORD         = bword_q;
  assign BUF_DATA         = bdata_q;
  assign BUF_CLEAR        = bclr_q;
  assign LOCK_PROG        = lprog_q;
  assign LOCK_PROG_DATA   = ldat_q;
  assign FUSE_WR_GRANT    = fgrant_q;
  assign FUSE_LOW         = fuse_low_w;
  assign FUSE_HIGH        = fuse_high_w;

endmodule // self_program_flash_control

// File: hw/spm_ctrl_defs.svh
// Offsets, field positions and cycle counts of the self-programming control.
// Assumes inclusion by bare name; holds definitions only.
`ifndef SPM_CTRL_DEFS_SVH
`define SPM_CTRL_DEFS_SVH

// Control/status register bit positions.
`define CSR_IRQ_EN_BIT     7
`define CSR_RWW_BUSY_BIT   6
`define CSR_RESERVED_BIT   5
`define CSR_RWW_RD_EN_BIT  4
`define CSR_LOCK_SET_BIT   3
`define CSR_PAGE_WR_BIT    2
`define CSR_PAGE_ERS_BIT   1
`define CSR_SELF_EN_BIT    0
`define CSR_RESET          8'h00
`define CSR_CMD_MASK       8'h1f

// Arming patterns of the low five control bits.
`define PAT_FILL           5'h01
`define PAT_ERASE          5'h03
`define PAT_WRITE          5'h05
`define PAT_LOCK           5'h09
`define PAT_RWW            5'h11

// Command windows in CPU cycles.
`define STORE_WINDOW_CYC   3'h4
`define LOAD_WINDOW_CYC    3'h3

// Pointer readback selectors.
`define Z_FUSE_LOW         2'h0
`define Z_LOCK             2'h1
`define Z_FUSE_HIGH        2'h3
`define RD_UNUSED          8'hff

// Pointer fields.
`define Z_PAGE_MSB         13
`define Z_PAGE_LSB         7
`define Z_WORD_MSB         6
`define Z_WORD_LSB         1

// Lock byte write: bits 5..2 from the data register, the rest kept at one.
`define LOCK_KEEP_MASK     8'hc3
`define LOCK_FIRST_BIT     0
`define FUSE_HIGH_IMM_MASK 8'h08

`endif

// File: hw/spm_ctrl_pkg.sv
// Types shared by the self-programming control.
// Assumes the defs header is included by the design files that need it.
package spm_ctrl_pkg;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_ARMED = 3'b010,
    ST_BUSY  = 3'b100
  } seq_state_e;

  typedef logic [7:0] byte_t;

endpackage

// File: hw/cmd_window.sv
// Down-counter that holds a command window open for a number of cycles.
// Assumes start and stop come from logic on the same clock.
`timescale 1ns/1ns
module cmd_window #(
  parameter int          WIDTH = 3,
  parameter logic [WIDTH-1:0] LOAD = 3'h4
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // Control
  input  wire logic start,
  input  wire logic stop,
  // Status
  output logic      open,
  output logic      expire
);

  logic [WIDTH-1:0] cnt_q;

  assign open   = (cnt_q != '0);
  assign expire = (cnt_q == WIDTH'(1)) && !stop;

  always_ff @(posedge clk) begin
    if (rst || stop) begin
      cnt_q <= '0;
    end else if (start) begin
      cnt_q <= LOAD;
    end else if (open) begin
      cnt_q <= cnt_q - WIDTH'(1);
    end
  end

endmodule // cmd_window

// File: hw/fuse_latch.sv
// Holds the fuse byte in force: caught after reset and on programming exit; IMM_MASK bits follow raw every cycle.
// Assumes raw comes from the fuse array on the same clock, prog_mode synced.
`timescale 1ns/1ns
module fuse_latch #(
  parameter logic [7:0] IMM_MASK = 8'h00
) (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // Fuse array side
  input  wire logic [7:0] raw,
  input  wire logic       prog_mode,
  // Value in force
  output logic      [7:0] value
);

  logic [7:0] live_q;
  logic [7:0] value_q;
  logic       first_q;
  logic       pm_q;
  logic       leave;
  logic [7:0] live_d;

  // Leaving programming mode applies the values changed inside it.
  assign leave  = pm_q && !prog_mode;
  assign live_d = (first_q || leave) ? raw : live_q;
  assign value  = value_q;

  always_ff @(posedge clk) begin
    if (rst) begin
      first_q <= 1'b1;
      pm_q    <= 1'b0;
      live_q  <= 8'h00;
      value_q <= 8'h00;
    end else begin
      first_q <= 1'b0;
      pm_q    <= prog_mode;
      live_q  <= live_d;
      value_q <= (live_d & ~IMM_MASK) | (raw & IMM_MASK);
    end
  end

endmodule // fuse_latch

// File: bench/spm_ctrl_checker.sv
// Port-level checks of the self-programming control.
// Assumes one clock domain with a synchronous active-high reset.
`timescale 1ns/1ns
module spm_ctrl_checker (
  // Clock and reset
  input wire logic        CORE_CLK,
  input wire logic        RESET,
  // Core side
  input wire logic        CSR_WR_EN,
  input wire logic [7:0]  CSR_WR_DATA,
  input wire logic [7:0]  CSR_RD_DATA,
  input wire logic        STORE_PROG_MEM_OP,
  input wire logic        LOAD_PROG_MEM_OP,
  input wire logic [15:0] Z_PTR,
  input wire logic [7:0]  LOW_DATA_REG,
  input wire logic        GLOBAL_IRQ_EN,
  input wire logic        LOAD_OVERRIDE,
  input wire logic [7:0]  LOAD_DATA,
  input wire logic        CPU_HALT,
  input wire logic        PROG_READY_IRQ,
  // Flash and lock side
  input wire logic        PAGE_WRITE_START,
  input wire logic [6:0]  PAGE_ADDR,
  input wire logic        FLASH_DONE,
  input wire logic [7:0]  LOCK_BITS_NV,
  input wire logic        LOCK_PROG,
  input wire logic [7:0]  LOCK_PROG_DATA,
  input wire logic        EEPROM_WRITE_ACTIVE
);
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (RESET);
  wire logic [6:0] z_page = Z_PTR[13:7];
  wire logic [4:0] cmd = CSR_RD_DATA[4:0];
  wire logic self_en = CSR_RD_DATA[0];
  wire logic ee = EEPROM_WRITE_ACTIVE;
  wire logic st = STORE_PROG_MEM_OP && !ee && !CPU_HALT;
  wire logic rd = LOAD_PROG_MEM_OP && !ee && cmd == 5'h09;

  a_rww_busy_zero: assert property (CSR_RD_DATA[6] == 1'b0)
    else $error("busy bit set");
  a_resv_bit_zero: assert property (CSR_WR_EN && CSR_WR_DATA[5] |=> !CSR_RD_DATA[5])
    else $error("reserved bit set");
  a_irq_needs_en: assert property (PROG_READY_IRQ |-> $past(GLOBAL_IRQ_EN) && !$past(self_en))
    else $error("irq without enables");
  a_irq_quiet_ee: assert property (ee |=> !PROG_READY_IRQ)
    else $error("irq during eeprom write");
  a_page_write_go: assert property (st && cmd == 5'h05 |=>
    PAGE_WRITE_START && CPU_HALT && PAGE_ADDR == $past(z_page))
    else $error("page write not started");
  a_done_releases: assert property (CPU_HALT && FLASH_DONE |=> !CPU_HALT && cmd == 5'h00)
    else $error("halt not released");
  a_erase_expires: assert property (CSR_WR_EN && CSR_WR_DATA[4:0] == 5'h03 && !ee && !CPU_HALT
    ##1 (!STORE_PROG_MEM_OP && !CSR_WR_EN) [*4] |=> cmd == 5'h00)
    else $error("erase window stuck");
  a_lock_expires: assert property (CSR_WR_EN && CSR_WR_DATA[4:0] == 5'h09 && !ee && !CPU_HALT
    ##1 (!LOAD_PROG_MEM_OP && !STORE_PROG_MEM_OP && !CSR_WR_EN) [*3] |=> cmd == 5'h00)
    else $error("lock window stuck");
  a_lock_readback: assert property (rd && Z_PTR[1:0] == 2'h1 |=>
    LOAD_OVERRIDE && LOAD_DATA == $past(LOCK_BITS_NV))
    else $error("lock readback wrong");
  a_lock_program: assert property (st && cmd == 5'h09 |=>
    LOCK_PROG && !CPU_HALT && LOCK_PROG_DATA == ($past(LOW_DATA_REG) | 8'hc3))
    else $error("lock write wrong");
  a_ee_blocks_ops: assert property (ee && (STORE_PROG_MEM_OP || LOAD_PROG_MEM_OP) |=>
    !LOAD_OVERRIDE && !LOCK_PROG && !PAGE_WRITE_START)
    else $error("op during eeprom write");
  c_page_write: cover property (PAGE_WRITE_START);
  c_lock_prog: cover property (LOCK_PROG);
  c_readback: cover property (LOAD_OVERRIDE);
endmodule // spm_ctrl_checker

// File: bench/flash_array_model.sv
// Flash array stand-in: ends page operations after a set delay, keeps lock byte.
// Assumes one-cycle start pulses on clk; programmed lock bits only go to zero.
`timescale 1ns/1ns
module flash_array_model (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // Requests
  input  wire logic       start,
  input  wire logic       lock_wr,
  input  wire logic [7:0] lock_data,
  input  wire logic [3:0] delay,
  // Answers
  output logic            done,
  output logic      [7:0] lock_byte
);
  logic [4:0] cnt_q;
  always_ff @(posedge clk) begin
    done <= 1'b0;
    if (rst) begin
      cnt_q <= 5'h00;
      lock_byte <= 8'hff;
    end else begin
      if (start) cnt_q <= {1'b0, delay} + 5'h01;
      else if (cnt_q != 5'h00) cnt_q <= cnt_q - 5'h01;
      if (cnt_q == 5'h01) done <= 1'b1;
      if (lock_wr) lock_byte <= lock_byte & lock_data;
    end
  end
endmodule // flash_array_model

// File: bench/tb_self_program_flash_control.sv
// Self-checking bench for the self-programming control.
// Assumes the checker and flash model are compiled before this file.
`timescale 1ns/1ns
`include "spm_ctrl_defs.svh"
module tb_self_program_flash_control;
  logic clk, rst, wr_en, st_op, ld_op, g_irq, ee, done, ovr, halt, irq;
  logic ers, wst, bwr, bclr, lkp, fwr, fgr, pm;
  logic [7:0] wr_d, rd_d, lo_d, hi_d, ld_d, lk_nv, lk_d, flr, fhr, fl, fh, v, t, o_lo, o_hi;
  logic [15:0] z, bdat;
  logic [6:0] pg;
  logic [5:0] bwd;
  logic [3:0] dly;
  logic [31:0] rs = 32'h1;
  int err_count, samples_checked, n_buf, n_clr, n_ers, i, k;

  self_program_flash_control dut (.CORE_CLK(clk), .RESET(rst), .CSR_WR_EN(wr_en),
    .CSR_WR_DATA(wr_d), .CSR_RD_DATA(rd_d), .STORE_PROG_MEM_OP(st_op),
    .LOAD_PROG_MEM_OP(ld_op), .Z_PTR(z), .LOW_DATA_REG(lo_d), .HIGH_DATA_REG(hi_d),
    .GLOBAL_IRQ_EN(g_irq), .LOAD_OVERRIDE(ovr), .LOAD_DATA(ld_d), .CPU_HALT(halt),
    .PROG_READY_IRQ(irq), .PAGE_ERASE_START(ers), .PAGE_WRITE_START(wst),
    .PAGE_ADDR(pg), .BUF_WR(bwr), .BUF_WORD(bwd), .BUF_DATA(bdat), .BUF_CLEAR(bclr),
    .FLASH_DONE(done), .LOCK_BITS_NV(lk_nv), .LOCK_PROG(lkp), .LOCK_PROG_DATA(lk_d),
    .FUSE_LOW_RAW(flr), .FUSE_HIGH_RAW(fhr), .FUSE_WR_REQ(fwr), .FUSE_WR_GRANT(fgr),
    .FUSE_LOW(fl), .FUSE_HIGH(fh), .EEPROM_WRITE_ACTIVE(ee), .PROG_MODE_PIN(pm));
  flash_array_model u_flash (.clk(clk), .rst(rst), .start(ers | wst), .lock_wr(lkp),
    .lock_data(lk_d), .delay(dly), .done(done), .lock_byte(lk_nv));

  function logic [7:0] rnd8();
    rs = rs ^ (rs << 13);
    rs = rs ^ (rs >> 17);
    rs = rs ^ (rs << 5);
    return rs[7:0];
  endfunction
  function logic [7:0] rb_exp(input logic [1:0] s, input logic [7:0] lk);
    case (s)
      2'h0: return flr;
      2'h1: return lk;
      2'h3: return fhr;
      default: return 8'hff;
    endcase
  endfunction
  task chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // One call drives one cycle of core strobes, so no strobe is assigned twice per edge.
  task cyc(input logic w, input logic [7:0] d, input logic s, input logic l);
    @(posedge clk);
    wr_en <= w;
    wr_d <= d;
    st_op <= s;
    ld_op <= l;
  endtask
  task idle(input int n);
    repeat (n) cyc(1'b0, 8'h00, 1'b0, 1'b0);
  endtask
  task give_verdict;
    $display("comparisons %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  always @(posedge clk) begin
    if (bwr === 1'b1) n_buf++;
    if (bclr === 1'b1) n_clr++;
    if (ers === 1'b1) n_ers++;
  end
  initial begin
    repeat (3000) @(posedge clk);
    err_count++;
    give_verdict();
  end

  initial begin
    {rst, wr_en, st_op, ld_op, g_irq, ee, fwr, pm} = 8'h80;
    {wr_d, lo_d, hi_d, z, dly} = '0;
    flr = rnd8();
    fhr = rnd8();
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    idle(2);
    #1;
    chk("csr reset", 8'h00, rd_d);
    chk("lock data reset", 8'hff, lk_d);
    chk("fuse low", flr, fl);
    for (i = 0; i < 6; i++) begin
      t = (i == 0) ? 8'hfe : (rnd8() & 8'hfe);
      cyc(1'b1, t, 1'b0, 1'b0);
      idle(1);
      #1;
      chk("csr bits", t & 8'h80, rd_d);
    end
    g_irq <= 1'b1;
    cyc(1'b1, 8'h80, 1'b0, 1'b0);
    idle(3);
    #1;
    chk("irq on", 8'h01, {7'h00, irq});
    ee <= 1'b1;
    idle(3);
    ee <= 1'b0;
    #1;
    chk("irq eeprom", 8'h00, {7'h00, irq});
    v = rnd8() | 8'hc3;
    lo_d <= v;
    cyc(1'b1, 8'h09, 1'b0, 1'b0);
    cyc(1'b0, 8'h00, 1'b1, 1'b0);
    idle(3);
    #1;
    chk("lock byte", v, lk_nv);
    chk("csr lock done", 8'h00, rd_d);
    for (i = 0; i < 4; i++) begin
      @(posedge clk);
      z <= {rnd8(), 6'h00, 2'(i)};
      cyc(1'b1, 8'h09, 1'b0, 1'b0);
      idle(i % 3);
      cyc(1'b0, 8'h00, 1'b0, 1'b1);
      idle(2);
      #1;
      chk("readback", rb_exp(2'(i), v), ld_d);
    end
    for (i = 0; i < 2; i++) begin
      cyc(1'b1, i ? 8'h03 : 8'h09, 1'b0, 1'b0);
      idle(i ? 4 : 3);
      #1;
      chk("window open", i ? 8'h03 : 8'h09, rd_d);
      idle(1);
      #1;
      chk("window expiry", 8'h00, rd_d);
    end
    for (i = 0; i < 2; i++) begin
      @(posedge clk);
      t = rnd8();
      z <= {2'b11, t[6:0], 7'h00};
      dly <= i ? 4'h9 : 4'h1;
      cyc(1'b1, i ? 8'h05 : 8'h03, 1'b0, 1'b0);
      cyc(1'b0, 8'h00, 1'b1, 1'b0);
      idle(2);
      #1;
      chk("page addr", {1'b0, t[6:0]}, {1'b0, pg});
      chk("halt", 8'h01, {7'h00, halt});
      for (k = 0; k < 30 && halt !== 1'b0; k++) idle(1);
      #1;
      chk("halt end", 8'h00, {7'h00, halt});
      chk("csr page done", 8'h00, rd_d);
    end
    chk("erase starts", 8'h01, 8'(n_ers));
    ee <= 1'b1;
    cyc(1'b1, 8'h05, 1'b0, 1'b0);
    cyc(1'b0, 8'h00, 1'b1, 1'b1);
    idle(3);
    ee <= 1'b0;
    #1;
    chk("csr blocked", 8'h00, rd_d);
    chk("halt blocked", 8'h00, {7'h00, halt});
    @(posedge clk);
    t = rnd8();
    z <= {9'h000, t[5:0], 1'b0};
    hi_d <= rnd8();
    cyc(1'b1, 8'h01, 1'b0, 1'b0);
    cyc(1'b0, 8'h00, 1'b1, 1'b0);
    idle(2);
    #1;
    chk("buf word", {2'b00, t[5:0]}, {2'b00, bwd});
    chk("buf low", lo_d, bdat[7:0]);
    chk("buf high", hi_d, bdat[15:8]);
    cyc(1'b1, 8'h11, 1'b0, 1'b0);
    idle(3);
    o_lo = flr;
    o_hi = fhr;
    flr <= ~flr;
    fhr <= ~fhr;
    #1;
    chk("buf writes", 8'h01, 8'(n_buf));
    chk("buf clears", 8'h01, 8'(n_clr));
    idle(3);
    #1;
    chk("fuse low held", o_lo, fl);
    chk("fuse high", o_hi ^ `FUSE_HIGH_IMM_MASK, fh);
    fwr <= 1'b1;
    pm <= 1'b1;
    idle(4);
    #1;
    chk("fuse grant", 8'h01, {7'h00, fgr});
    chk("fuse low in prog", o_lo, fl);
    fwr <= 1'b0;
    pm <= 1'b0;
    idle(5);
    #1;
    chk("fuse low applied", ~o_lo, fl);
    chk("fuse grant off", 8'h00, {7'h00, fgr});
    give_verdict();
  end
endmodule // tb_self_program_flash_control
bind self_program_flash_control spm_ctrl_checker u_chk (.*);
